// ### cct_pkg.sv
package cct_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam int             ADDR_W     = 8;
   localparam logic [7:0]     A_CTRL1    = 8'h00;
   localparam logic [7:0]     A_CTRL2    = 8'h04;
   localparam logic [7:0]     A_STATUS   = 8'h08;
   localparam logic [7:0]     A_CNT_HI   = 8'h1C;
   localparam logic [7:0]     A_CNT_LO   = 8'h20;
   localparam logic [7:0]     A_ACNT_HI  = 8'h24;
   localparam logic [7:0]     A_ACNT_LO  = 8'h28;
   localparam logic [1:0][7:0] A_IC_HI   = {8'h2C, 8'h0C};
   localparam logic [1:0][7:0] A_IC_LO   = {8'h30, 8'h10};
   localparam logic [1:0][7:0] A_OC_HI   = {8'h34, 8'h14};
   localparam logic [1:0][7:0] A_OC_LO   = {8'h38, 8'h18};

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int C1_CAPTURE_IRQ_ENABLE  = 7;
   localparam int C1_COMPARE_IRQ_ENABLE  = 6;
   localparam int C1_OVERFLOW_IRQ_ENABLE  = 5;
   localparam int C1_OLVL2 = 2;
   localparam int C1_IEDG1 = 1;
   localparam int C1_OLVL1 = 0;
   localparam int C2_OC1E  = 7;
   localparam int C2_OC2E  = 6;
   localparam int C2_OPM   = 5;
   localparam int C2_PWM   = 4;
   localparam int C2_CS    = 2;
   localparam int C2_IEDG2 = 1;
   localparam int C2_EXT_EDGE_SELECT = 0;
   localparam int S_ICF1   = 7;
   localparam int S_OCF1   = 6;
   localparam int S_TOF    = 5;
   localparam int S_ICF2   = 4;
   localparam int S_OCF2   = 3;

   // ----------------------------------------------------------------
   // Clock select codes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  CS_DIV4    = 2'h0;
   localparam logic [1:0]  CS_DIV8    = 2'h1;
   localparam logic [1:0]  CS_DIV2    = 2'h2;
   localparam logic [1:0]  CS_EXT     = 2'h3;
   localparam logic [15:0] CNT_RESET  = 16'hFFFC;
   localparam logic [15:0] CNT_TOP    = 16'hFFFF;
   localparam logic [15:0] CMP_RESET  = 16'h8000;

   // Active edge of a synchronised level; rise selects rising edge
   function automatic logic sel_edge(logic prev, logic cur, logic rise);
      sel_edge = rise ? (cur & ~prev) : (prev & ~cur);
   endfunction

endpackage

// ### cct_timer.sv
`timescale 1ns/10ps
// Notes on behaviour
// - 16-bit up-counter read as a high byte and a low byte.
// - Alternate view of the counter; its low byte write reloads, its access keeps overflow.
// - Writing either counter low byte reloads the counter with FFFCh.
// - Counter resets to FFFCh in every mode; only value ever reloaded.
// - Clock select picks CPU clock /2, /4, /8 or the external clock.
// - Both select bits one: count on external pin, edge chosen by bit.
// - External edges synchronised; source leaves four CPU edges between.
// - High byte read first buffers low byte until the low byte is read.
// - Without pending sequence, low byte read returns the live count.
// - Overflow flag sets when the counter wraps FFFFh to 0000h.
// - Overflow interrupt when enabled and CPU mask clear, else pending.
// - Overflow flag clears by status read then counter low access.
// - Counts in wait, freezes in halt, resumes held or reset count.
// - Flash variant: no capture 2, compare 2 write-only, flags zero.
// - Each capture edge latches the count and sets its capture flag.
// - Capture edge chosen per channel by its own edge select bit.
// - One capture enable covers both channels, gated by CPU mask.
// - Capture flag clears by status read then capture low access.
// - Capture high read blocks capture and flag until low read.
// - In one pulse and PWM modes only capture channel 2 captures.
// - Capture pins always feed the timer, whatever the pin direction.
// - Each tick compare both channels; match sets flag, pin, interrupt.
// - Compare registers software-only, reset to 8000h.
// - Match drives compare pin to its output level; pin low at reset.
// - Compare flag clears by status read then compare low access.
// - Compare high write inhibits compares until low byte written.
module cct_timer #(
   parameter int FLASH_VARIANT = 0
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [cct_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic [1:0]                 capture_pin,
   input  wire logic                       ext_clock_pin,
   input  wire logic                       cpu_irq_mask,
   input  wire logic                       halt_mode,
   output logic      [1:0]                 compare_pin,
   output logic                            timer_irq
);
   import cct_pkg::*;

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (FLASH_VARIANT < 0 || FLASH_VARIANT > 1)
   begin : g_chk
      $error("FLASH_VARIANT must be 0 or 1");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       ctrl1;
      logic [7:0]       ctrl2;
      logic [15:0]      cnt;
      logic [2:0]       presc;
      logic             fresh;
      logic [7:0]       lo_buf;
      logic             lo_pend;
      logic             overflow_flag;
      logic             tof_arm;
      logic [1:0][15:0] icv;
      logic [1:0]       ic_inh;
      logic [1:0]       icf;
      logic [1:0]       icf_arm;
      logic [1:0][15:0] ocv;
      logic [1:0]       oc_inh;
      logic [1:0]       ocf;
      logic [1:0]       ocf_arm;
      logic [1:0]       cmp_pin;
      logic [1:0]       cap_s1;
      logic [1:0]       cap_s2;
      logic [1:0]       cap_prev;
      logic             ext_s1;
      logic             ext_s2;
      logic             ext_prev;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic             irq;
   } cct_state_t;

   cct_state_t st;
   cct_state_t nx;

   logic       req;
   logic       rd;
   logic       wr;
   logic [1:0] cs;
   logic       ext_edge;
   logic       tick;
   logic       ovf;
   logic       reload;
   logic       mode_alt;
   logic [1:0] edge_sel;
   logic [1:0] oc_en;
   logic [1:0] olvl;
   logic [1:0] ch_ok;

   // ----------------------------------------------------------------
   // Request decode and timer tick
   // ----------------------------------------------------------------
   // All side effects act at the setup edge; the answer follows one
   // cycle later with pready, so data and effects agree.
   assign req = psel & ~penable;
   assign rd  = req & ~pwrite;
   assign wr  = req & pwrite;
   assign cs  = st.ctrl2[C2_CS +: 2];
   assign ext_edge = sel_edge(st.ext_prev, st.ext_s2,
                              st.ctrl2[C2_EXT_EDGE_SELECT]);
   assign tick = ~halt_mode &
                 ((cs == CS_DIV2) ? st.presc[0] :
                  (cs == CS_DIV4) ? &st.presc[1:0] :
                  (cs == CS_DIV8) ? &st.presc : ext_edge);
   assign ovf      = tick & (st.cnt == CNT_TOP);
   assign reload   = wr & ((paddr == A_CNT_LO) |
                           (paddr == A_ACNT_LO));
   assign mode_alt = st.ctrl2[C2_OPM] | st.ctrl2[C2_PWM];
   assign edge_sel = {st.ctrl2[C2_IEDG2], st.ctrl1[C1_IEDG1]};
   assign oc_en    = {st.ctrl2[C2_OC2E], st.ctrl2[C2_OC1E]};
   assign olvl     = {st.ctrl1[C1_OLVL2], st.ctrl1[C1_OLVL1]};
   // Second channel exists only outside the flash variant
   assign ch_ok    = {FLASH_VARIANT == 0, 1'b1};

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic [7:0] rdb;
      logic       miss;
      logic       cap_ok;
      rdb  = 8'h00;
      miss = 1'b0;
      cap_ok = 1'b0;
      nx = st;

      // Two-stage synchronisers; captures see every pin transition
      nx.cap_s1   = capture_pin;
      nx.cap_s2   = st.cap_s1;
      nx.cap_prev = st.cap_s2;
      nx.ext_s1   = ext_clock_pin;
      nx.ext_s2   = st.ext_s1;
      nx.ext_prev = st.ext_s2;

      // Prescaler and counter, both held in halt
      if (!halt_mode)
      begin
         nx.presc = st.presc + 3'h1;
      end
      nx.fresh = tick;
      if (reload)
      begin
         nx.cnt = CNT_RESET;
      end
      else if (tick)
      begin
         nx.cnt = st.cnt + 16'h0001;
      end

      // Control writes
      if (wr && paddr == A_CTRL1)
      begin
         nx.ctrl1 = pwdata[7:0];
      end
      if (wr && paddr == A_CTRL2)
      begin
         nx.ctrl2 = pwdata[7:0];
      end

      // Coherent 16-bit counter read
      if (rd && (paddr == A_CNT_HI || paddr == A_ACNT_HI) && !st.lo_pend)
      begin
         nx.lo_buf  = st.cnt[7:0];
         nx.lo_pend = 1'b1;
      end
      if (rd && (paddr == A_CNT_LO || paddr == A_ACNT_LO))
      begin
         nx.lo_pend = 1'b0;
      end

      // Overflow flag; a new overflow beats a clear in the same cycle
      if (rd && paddr == A_STATUS && st.overflow_flag)
      begin
         nx.tof_arm = 1'b1;
      end
      if (req && paddr == A_CNT_LO && st.tof_arm)
      begin
         nx.overflow_flag     = 1'b0;
         nx.tof_arm = 1'b0;
      end
      if (ovf)
      begin
         nx.overflow_flag = 1'b1;
      end

      for (int i = 0; i < 2; i++)
      begin
         // Capture channel
         if (rd && paddr == A_STATUS && st.icf[i])
         begin
            nx.icf_arm[i] = 1'b1;
         end
         if (rd && paddr == A_IC_HI[i])
         begin
            nx.ic_inh[i] = 1'b1;
         end
         if (rd && paddr == A_IC_LO[i])
         begin
            nx.ic_inh[i] = 1'b0;
         end
         if (req && paddr == A_IC_LO[i] && st.icf_arm[i])
         begin
            nx.icf[i]     = 1'b0;
            nx.icf_arm[i] = 1'b0;
         end
         cap_ok = ch_ok[i] & ~st.ic_inh[i] & ((i != 0) | ~mode_alt);
         if (cap_ok && sel_edge(st.cap_prev[i], st.cap_s2[i], edge_sel[i]))
         begin
            nx.icv[i] = st.cnt;
            nx.icf[i] = 1'b1;
         end

         // Compare channel
         if (rd && paddr == A_STATUS && st.ocf[i])
         begin
            nx.ocf_arm[i] = 1'b1;
         end
         if (wr && paddr == A_OC_HI[i])
         begin
            nx.ocv[i][15:8] = pwdata[7:0];
            nx.oc_inh[i]    = 1'b1;
         end
         if (wr && paddr == A_OC_LO[i])
         begin
            nx.ocv[i][7:0] = pwdata[7:0];
            nx.oc_inh[i]   = 1'b0;
         end
         if (req && paddr == A_OC_LO[i] && st.ocf_arm[i])
         begin
            nx.ocf[i]     = 1'b0;
            nx.ocf_arm[i] = 1'b0;
         end
         if (ch_ok[i] && st.fresh && !st.oc_inh[i] && st.cnt == st.ocv[i])
         begin
            nx.ocf[i] = 1'b1;
            if (oc_en[i])
            begin
               nx.cmp_pin[i] = olvl[i];
            end
         end
      end

      // Read data mux
      case (paddr)
         A_CTRL1:   rdb = st.ctrl1;
         A_CTRL2:   rdb = st.ctrl2;
         A_STATUS:
         begin
            rdb[S_ICF1] = st.icf[0];
            rdb[S_OCF1] = st.ocf[0];
            rdb[S_TOF]  = st.overflow_flag;
            rdb[S_ICF2] = st.icf[1];
            rdb[S_OCF2] = st.ocf[1];
         end
         A_CNT_HI,
         A_ACNT_HI: rdb = st.cnt[15:8];
         A_CNT_LO,
         A_ACNT_LO: rdb = st.lo_pend ? st.lo_buf : st.cnt[7:0];
         A_IC_HI[0]: rdb = st.icv[0][15:8];
         A_IC_LO[0]: rdb = st.icv[0][7:0];
         A_OC_HI[0]: rdb = st.ocv[0][15:8];
         A_OC_LO[0]: rdb = st.ocv[0][7:0];
         A_IC_HI[1]: rdb = ch_ok[1] ? st.icv[1][15:8] : 8'h00;
         A_IC_LO[1]: rdb = ch_ok[1] ? st.icv[1][7:0] : 8'h00;
         A_OC_HI[1]: rdb = ch_ok[1] ? st.ocv[1][15:8] : 8'h00;
         A_OC_LO[1]: rdb = ch_ok[1] ? st.ocv[1][7:0] : 8'h00;
         default:   miss = 1'b1;
      endcase

      nx.pready  = req;
      nx.pslverr = req & miss;
      nx.prdata  = rd ? {24'h000000, rdb} : 32'h00000000;

      // Interrupt request, pending while masked or disabled
      nx.irq = ~cpu_irq_mask &
               ((st.overflow_flag & st.ctrl1[C1_OVERFLOW_IRQ_ENABLE]) |
                ((|st.icf) & st.ctrl1[C1_CAPTURE_IRQ_ENABLE]) |
                ((|st.ocf) & st.ctrl1[C1_COMPARE_IRQ_ENABLE]));
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st     <= '0;
         st.cnt <= CNT_RESET;
         st.ocv <= {CMP_RESET, CMP_RESET};
      end
      else
      begin
         st <= nx;
      end
   end

   assign prdata      = st.prdata;
   assign pready      = st.pready;
   assign pslverr     = st.pslverr;
   assign compare_pin = st.cmp_pin;
   assign timer_irq   = st.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_cnt_lo_acc;
      req && paddr == A_CNT_LO;
   endsequence

   sequence s_alt_lo_acc;
      req && paddr == A_ACNT_LO;
   endsequence

   sequence s_hi_read;
      rd && paddr == A_CNT_HI && !st.lo_pend;
   endsequence

   a_reload_low: assert property (reload |=> st.cnt == 16'hFFFC)
      else $error("counter not reloaded on low byte write");

   a_count_step: assert property (
      !$past(reload) && $changed(st.cnt) |->
      st.cnt == $past(st.cnt) + 16'h0001)
      else $error("counter moved by other than one");

   a_halt_freeze: assert property (
      halt_mode && !reload |=> $stable(st.cnt))
      else $error("counter moved in halt");

   a_ovf_set: assert property (
      ovf && !reload |=> st.overflow_flag && st.cnt == 16'h0000)
      else $error("wrap did not set overflow flag");

   a_tof_clear: assert property (
      st.tof_arm && !ovf ##0 s_cnt_lo_acc |=> !st.overflow_flag)
      else $error("armed overflow flag not cleared");

   a_alt_keeps: assert property (
      st.overflow_flag ##0 s_alt_lo_acc |=> st.overflow_flag)
      else $error("alternate low access cleared overflow");

   a_lo_buffer: assert property (
      s_hi_read ##1 (!(rd && paddr == A_CNT_LO) && !reload) [*3]
      |-> st.lo_buf == $past(st.cnt[7:0], 3))
      else $error("buffered low byte changed");

   a_cap_block: assert property (
      st.ic_inh[0] |=> $stable(st.icv[0]))
      else $error("capture taken while blocked");

   a_cmp_inhibit: assert property (
      st.oc_inh[0] && !(req && paddr == A_OC_LO[0] && st.ocf_arm[0])
      |=> st.ocf[0] == $past(st.ocf[0]))
      else $error("compare flag set while inhibited");

   a_irq_mask: assert property (
      cpu_irq_mask |=> !timer_irq)
      else $error("interrupt raised while masked");

   a_irq_ovf: assert property (
      st.overflow_flag && st.ctrl1[C1_OVERFLOW_IRQ_ENABLE] && !cpu_irq_mask |=> timer_irq)
      else $error("pending overflow interrupt not raised");

   a_flash_zero: assert property (
      FLASH_VARIANT == 1 |-> st.icf[1] == 1'b0 && st.ocf[1] == 1'b0)
      else $error("second channel flag set in flash variant");

   a_apb_answer: assert property (
      req |=> pready ##1 !pready)
      else $error("bus answer not one cycle after setup");

endmodule // cct_timer

// ### cct_pins_model.sv
`timescale 1ns/10ps
module cct_pins_model (
   input  wire logic       pclk,
   output logic [1:0]      capture_pin,
   output logic            ext_clock_pin
);
   initial
   begin
      capture_pin   = 2'h0;
      ext_clock_pin = 1'b0;
   end

   // Capture pins follow the host's command
   task automatic set_cap(input int ch, input logic lvl);
      @(posedge pclk);
      capture_pin[ch] <= lvl;
   endtask

   // Pulses four clocks high, one every nine clocks, so active edges stay well apart
   task automatic ext_pulses(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         ext_clock_pin <= 1'b1;
         repeat (4) @(posedge pclk);
         ext_clock_pin <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask
endmodule // cct_pins_model

// ### cct_timer_tb_top.sv
`timescale 1ns/10ps
module cct_timer_tb_top;
   import cct_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  capture_pin;
   logic        ext_clock_pin;
   logic        cpu_irq_mask;
   logic        halt_mode;
   logic [1:0]  compare_pin;
   logic        timer_irq;
   logic [31:0] rd;
   logic [31:0] rd_f;
   logic [31:0] prdata_f;
   logic        err;
   logic [15:0] v;
   logic [15:0] w;
   int          fails;
   int          tests_run;
   logic [1:0]  cs_tab [3] = '{CS_DIV2, CS_DIV4, CS_DIV8};
   int          div_tab [3] = '{2, 4, 8};

   cct_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin),
      .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
      .compare_pin(compare_pin), .timer_irq(timer_irq));

   cct_pins_model pins (.pclk(pclk), .capture_pin(capture_pin),
      .ext_clock_pin(ext_clock_pin));

   // Flash variant on the same bus and pins; only its read data is watched
   cct_timer #(.FLASH_VARIANT(1)) dut_flash (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata_f), .pready(), .pslverr(),
      .capture_pin(capture_pin), .ext_clock_pin(ext_clock_pin),
      .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
      .compare_pin(), .timer_irq());

   always #25 pclk = ~pclk;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // APB transfer; held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         @(posedge pclk);
      end
      rd      = prdata;
      rd_f    = prdata_f;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      check(rd, exp);
   endtask

   task automatic rd16(input logic [7:0] ah, input logic [7:0] al);
      apb(1'b0, ah, 8'h00);
      v[15:8] = rd[7:0];
      apb(1'b0, al, 8'h00);
      v[7:0] = rd[7:0];
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic set_halt(input logic h);
      @(posedge pclk);
      halt_mode <= h;
   endtask

   task automatic run(input int n);
      set_halt(1'b0);
      cyc(n);
      set_halt(1'b1);
   endtask

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask

   initial
   begin
      repeat (20000) @(posedge pclk);
      fails++;
      $display("watchdog expired");
      close_out();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cpu_irq_mask = 1'b0;
      halt_mode = 1'b1;
      fails = 0;
      tests_run = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rdc(A_CNT_HI, 32'hFF);
      rdc(A_CNT_LO, 32'hFC);
      rdc(A_CTRL1, 32'h0);
      rdc(A_CTRL2, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         rdc(A_OC_HI[i], 32'h80);
         check(rd_f, (i == 1) ? 32'h0 : 32'h80);
         rdc(A_OC_LO[i], 32'h00);
      end
      check({30'h0, compare_pin}, 32'h0);
      apb(1'b0, 8'h3C, 8'h00);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      end_test("reset");
      rdc(A_CNT_HI, 32'hFF);
      run(40);
      rdc(A_CNT_HI, 32'h00);
      rdc(A_CNT_LO, 32'hFC);
      apb(1'b0, A_CNT_LO, 8'h00);
      check({31'h0, rd[7:0] >= 8'h05 && rd[7:0] <= 8'h07}, 32'h1);
      end_test("buffer");
      rdc(A_STATUS, 32'h20);
      wr(A_CTRL1, 8'h20);
      cyc(3);
      check({31'h0, timer_irq}, 32'h1);
      @(posedge pclk);
      cpu_irq_mask <= 1'b1;
      cyc(3);
      check({31'h0, timer_irq}, 32'h0);
      @(posedge pclk);
      cpu_irq_mask <= 1'b0;
      rdc(A_STATUS, 32'h20);
      apb(1'b0, A_ACNT_LO, 8'h00);
      rdc(A_STATUS, 32'h20);
      apb(1'b0, A_CNT_LO, 8'h00);
      rdc(A_STATUS, 32'h00);
      wr(A_CTRL1, 8'h00);
      end_test("overflow");
      for (int i = 0; i < 3; i++)
      begin
         wr(A_CTRL2, {4'h0, cs_tab[i], 2'h0});
         wr(A_CNT_LO, 8'h00);
         rd16(A_CNT_HI, A_CNT_LO);
         check({16'h0, v}, 32'hFFFC);
         run(div_tab[i] * 16);
         rd16(A_CNT_HI, A_CNT_LO);
         w = v - 16'hFFFC;
         check({31'h0, w >= 16'h000F && w <= 16'h0011}, 32'h1);
         w = v;
         cyc(20);
         rd16(A_ACNT_HI, A_ACNT_LO);
         check({16'h0, v}, {16'h0, w});
      end
      end_test("prescaler");
      for (int e = 0; e < 2; e++)
      begin
         wr(A_CTRL2, {4'h0, CS_EXT, 1'b0, e[0]});
         wr(A_CNT_LO, 8'h00);
         set_halt(1'b0);
         pins.ext_pulses(5);
         cyc(6);
         set_halt(1'b1);
         rd16(A_CNT_HI, A_CNT_LO);
         check({16'h0, v}, 32'h0001);
      end
      end_test("external clock");
      wr(A_CTRL1, 8'h82);
      wr(A_CTRL2, 8'h00);
      apb(1'b0, A_STATUS, 8'h00);
      wr(A_CNT_LO, 8'h00);
      pins.set_cap(0, 1'b1);
      cyc(6);
      rdc(A_STATUS, 32'h80);
      check({31'h0, timer_irq}, 32'h1);
      rd16(A_IC_HI[0], A_IC_LO[0]);
      check({16'h0, v}, 32'hFFFC);
      pins.set_cap(1, 1'b1);
      cyc(6);
      rdc(A_STATUS, 32'h00);
      pins.set_cap(1, 1'b0);
      cyc(6);
      rdc(A_STATUS, 32'h10);
      check(rd_f, 32'h0);
      apb(1'b0, A_IC_LO[0], 8'h00);
      rdc(A_STATUS, 32'h10);
      apb(1'b0, A_IC_HI[0], 8'h00);
      pins.set_cap(0, 1'b0);
      pins.set_cap(0, 1'b1);
      cyc(6);
      rdc(A_STATUS, 32'h10);
      apb(1'b0, A_IC_LO[0], 8'h00);
      pins.set_cap(0, 1'b0);
      pins.set_cap(0, 1'b1);
      cyc(6);
      rdc(A_STATUS, 32'h90);
      apb(1'b0, A_IC_LO[0], 8'h00);
      apb(1'b0, A_IC_LO[1], 8'h00);
      rdc(A_STATUS, 32'h00);
      wr(A_CTRL2, 8'h22);
      pins.set_cap(0, 1'b0);
      pins.set_cap(0, 1'b1);
      pins.set_cap(1, 1'b1);
      cyc(6);
      rdc(A_STATUS, 32'h10);
      apb(1'b0, A_IC_LO[1], 8'h00);
      wr(A_CTRL2, 8'h10);
      pins.set_cap(0, 1'b0);
      pins.set_cap(0, 1'b1);
      pins.set_cap(1, 1'b0);
      cyc(6);
      rdc(A_STATUS, 32'h10);
      end_test("capture");
      wr(A_CTRL2, 8'h88);
      wr(A_CTRL1, 8'h41);
      wr(A_OC_HI[0], 8'h00);
      apb(1'b0, A_STATUS, 8'h00);
      wr(A_CNT_LO, 8'h00);
      run(40);
      rdc(A_STATUS, 32'h30);
      check({30'h0, compare_pin}, 32'h0);
      wr(A_OC_LO[0], 8'h05);
      wr(A_CNT_LO, 8'h00);
      run(40);
      check({30'h0, compare_pin}, 32'h1);
      check({31'h0, timer_irq}, 32'h1);
      rdc(A_OC_HI[0], 32'h00);
      rdc(A_OC_LO[0], 32'h05);
      rdc(A_STATUS, 32'h70);
      wr(A_OC_LO[0], 8'h05);
      rdc(A_STATUS, 32'h30);
      end_test("compare");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd16(A_CNT_HI, A_CNT_LO);
      check({16'h0, v}, 32'hFFFC);
      rdc(A_STATUS, 32'h00);
      check({30'h0, compare_pin}, 32'h0);
      end_test("reset wake-up");
      close_out();
   end
endmodule // cct_timer_tb_top
